//--- rtl/oeb_pkg.sv
// Constants and types for the extension overhead bit block.
// Assumes a framer on the same clock that marks overhead bit slots.
// How it works
// RQ1: With power reporting on, frames 2 and 3 carry the two power bits.
// RQ2: With power reporting off, both power bits go out as ONE.
// RQ3: Power pair is 11 with both supplies good, 10 with backup bad only.
// RQ4: Power pair is 01 with primary bad, 00 when both supplies failed.
// RQ5: With test reporting on, frame 4 carries the test mode bit.
// RQ6: Test mode is any local maintenance on D, B1 or B2.
// RQ7: The test mode bit is ONE in normal use and ZERO in test mode.
// RQ8: With test reporting off, the test mode bit goes out as ONE.
// RQ9: Frame 5 carries ONE for a cold-start-only transceiver, else ZERO.
// RQ10: The far end carries its loop-only request in its frame 7.
// RQ11: The far end sends ONE to activate the T side and ZERO otherwise.
// RQ12: A far end without loop-only activation sends that bit as ONE.
// RQ13: With activity reporting on, frame 7 carries the T activity bit.
// RQ14: The activity bit is ONE while T request or T frame signal is seen.
// RQ15: With activity reporting off, the activity bit goes out as ONE.
// RQ16: The received frame 7 bit is taken once per aligned multiframe and held.
`default_nettype none
package oeb_pkg;
	// Frame numbers inside a multiframe, counted from one
	localparam logic [3:0] FR_PWR_FIRST  = 4'h2;
	localparam logic [3:0] FR_PWR_SECOND = 4'h3;
	localparam logic [3:0] FR_TEST       = 4'h4;
	localparam logic [3:0] FR_COLD       = 4'h5;
	localparam logic [3:0] FR_SEVENTH    = 4'h7;
	localparam logic [3:0] FR_LAST       = 4'h8;
	// Register byte offsets
	localparam logic [7:0] OFF_CTRL  = 8'h00;
	localparam logic [7:0] OFF_STAT  = 8'h04;
	localparam logic [7:0] OFF_ISTAT = 8'h08;
	localparam logic [7:0] OFF_IMASK = 8'h0C;
	// Control bits
	localparam int CB_PWR  = 0;
	localparam int CB_TEST = 1;
	localparam int CB_ACT  = 2;
	localparam int CB_COLD = 3;
	localparam logic [3:0] CTRL_RST  = 4'h0;
	localparam logic [3:0] IMASK_RST = 4'h0;
	// Edges after reset before the synchronised pin history is trusted
	localparam logic [1:0] PRIME_LAST = 2'h3;
	// Interrupt bits
	localparam int IB_LOOP = 0;
	localparam int IB_PWR  = 1;
	localparam int IB_TEST = 2;
	localparam int IB_ACT  = 3;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum {OEB_REG_CTRL, OEB_REG_STAT, OEB_REG_ISTAT, OEB_REG_IMASK,
		OEB_REG_NONE} oeb_reg_t;
	// Word address decode shared by read and write paths
	function automatic oeb_reg_t oeb_decode(input logic [7:0] a);
		oeb_reg_t r;
		r = OEB_REG_NONE;
		if (a[7:2] == OFF_CTRL[7:2]) r = OEB_REG_CTRL;
		if (a[7:2] == OFF_STAT[7:2]) r = OEB_REG_STAT;
		if (a[7:2] == OFF_ISTAT[7:2]) r = OEB_REG_ISTAT;
		if (a[7:2] == OFF_IMASK[7:2]) r = OEB_REG_IMASK;
		return r;
	endfunction
endpackage
`default_nettype wire

//--- rtl/oeb_sync.sv
// Two-flop synchroniser for a group of pin levels.
// Assumes each bit is a slow level; no bus coherence across bits.
`timescale 1ns/1ps
`default_nettype none
module oeb_sync #(
	parameter int W = 7
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic [W-1:0] pin_in,
	output logic      [W-1:0] lvl_out
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} oeb_sync_t;
	oeb_sync_t q, d;
	if (W < 1) begin : g_bad_w
		$error("oeb_sync: W must be at least 1");
	end
	// First stage feeds only the second stage
	always_comb begin
		d = q;
		d.s1 = pin_in;
		d.s2 = q.s1;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) q <= '0;
		else q <= d;
	end
	assign lvl_out = q.s2;
endmodule // oeb_sync
`default_nettype wire

//--- rtl/oeb_rx_capture.sv
// Capture of the far end's frame 7 overhead bit, once per multiframe.
// Assumes the framer marks each overhead bit with its frame number.
`timescale 1ns/1ps
`default_nettype none
module oeb_rx_capture
	import oeb_pkg::*;
(
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       rx_mf_aligned,
	input  wire logic       rx_m4_valid,
	input  wire logic [3:0] rx_frame_idx,
	input  wire logic       rx_m4_bit,
	output logic            loop_req,
	output logic            loop_valid,
	output logic            loop_chg
);
	typedef struct packed {
		logic pend;
		logic pend_ok;
		logic req;
		logic valid;
		logic chg;
	} oeb_rx_t;
	oeb_rx_t q, d;
	//////////////////////////////////////////////////////////////////////
	// Bit is staged at frame 7 and published at frame 8, so a multiframe
	// that loses alignment midway never leaks a half-seen value
	always_comb begin
		d = q;
		d.chg = 1'b0;
		if (!rx_mf_aligned) begin
			d.pend_ok = 1'b0;
			d.valid = 1'b0;
		end else if (rx_m4_valid) begin
			// RQ16 stage bit
			if (rx_frame_idx == FR_SEVENTH) begin
				d.pend = rx_m4_bit;
				d.pend_ok = 1'b1;
			end
			// RQ16 publish and hold
			if (rx_frame_idx == FR_LAST && q.pend_ok) begin
				d.req = q.pend;
				d.valid = 1'b1;
				d.chg = !q.valid || (q.req != q.pend);
				d.pend_ok = 1'b0;
			end
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) q <= '0;
		else q <= d;
	end
	assign loop_req = q.req;
	assign loop_valid = q.valid;
	assign loop_chg = q.chg;
	//////////////////////////////////////////////////////////////////////
	AST_RX_HOLD: assert property ( // RQ16
		@(posedge aclk) disable iff (!aresetn)
		(rx_mf_aligned && rx_m4_valid && rx_frame_idx == FR_LAST && q.pend_ok)
		|=> (loop_valid && loop_req == $past(q.pend)) ##1
		(!rx_m4_valid || !rx_mf_aligned || rx_frame_idx == FR_LAST
			|| $stable(loop_req)))
		else $error("received loop-only bit not captured or not held");
endmodule // oeb_rx_capture
`default_nettype wire

//--- rtl/oeb_top.sv
// Customer-side extension overhead bits: transmit encode, receive
// capture, AXI4-Lite registers and one level interrupt.
// Assumes a framer on aclk that asks for each outgoing overhead bit
// and marks each received one; supply and T-side lines are async pins.
`timescale 1ns/1ps
`default_nettype none
module oeb_top
	import oeb_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	output logic                   irq,
	input  wire logic              prim_pwr_ok,
	input  wire logic              bkup_pwr_ok,
	input  wire logic              maint_d,
	input  wire logic              maint_b1,
	input  wire logic              maint_b2,
	input  wire logic              tee_request_signal,
	input  wire logic              tee_frame_signal,
	input  wire logic              nt_active_signal,
	input  wire logic              tx_m4_req,
	input  wire logic [3:0]        tx_frame_idx,
	output logic                   tx_m4_bit,
	output logic                   tx_m4_valid,
	input  wire logic              rx_mf_aligned,
	input  wire logic              rx_m4_valid,
	input  wire logic [3:0]        rx_frame_idx,
	input  wire logic              rx_m4_bit,
	output logic                   loop_only_req,
	output logic                   loop_only_valid
);
	typedef struct packed {
		logic        aw_got;
		logic [7:0]  aw_addr;
		logic        w_got;
		logic [7:0]  w_byte;
		logic        w_en;
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [1:0]  rresp;
		logic [31:0] rdata;
		logic [3:0]  ctrl;
		logic [3:0]  istat;
		logic [3:0]  imask;
		logic        irq;
		logic        tx_bit;
		logic        tx_valid;
		logic [1:0]  prime_cnt;
		logic [1:0]  pwr_prev;
		logic        test_prev;
		logic        act_prev;
	} oeb_ctl_t;
	// Ready lines idle high; nothing else is under way after reset
	localparam oeb_ctl_t CTL_RST = '{
		aw_got: 1'b0, aw_addr: 8'h00, w_got: 1'b0, w_byte: 8'h00,
		w_en: 1'b0, awready: 1'b1, wready: 1'b1, bvalid: 1'b0,
		bresp: RESP_OKAY, arready: 1'b1, rvalid: 1'b0, rresp: RESP_OKAY,
		rdata: 32'h00000000, ctrl: CTRL_RST, istat: 4'h0,
		imask: IMASK_RST, irq: 1'b0, tx_bit: 1'b1, tx_valid: 1'b0,
		prime_cnt: 2'h0, pwr_prev: 2'h3, test_prev: 1'b0, act_prev: 1'b0};
	oeb_ctl_t q, d;
	logic [6:0] pin_s;
	logic       loop_chg;
	logic [1:0] pwr_pair;
	logic       in_test;
	logic       tee_act;
	// Refuse address widths the word decoder cannot serve
	if (ADDR_W < 4 || ADDR_W > 8) begin : g_bad_addr_w
		$error("oeb_top: ADDR_W must be 4..8");
	end
	//////////////////////////////////////////////////////////////////////
	// Pin levels except nt_active_signal cross into aclk before any decision looks at them; nt_active_signal goes raw into the status read
	oeb_sync #(.W(7)) u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.pin_in  ({tee_frame_signal, tee_request_signal, maint_b2,
			maint_b1, maint_d, bkup_pwr_ok, prim_pwr_ok}),
		.lvl_out (pin_s)
	);
	oeb_rx_capture u_rx (
		.aclk          (aclk),
		.aresetn       (aresetn),
		.rx_mf_aligned (rx_mf_aligned),
		.rx_m4_valid   (rx_m4_valid),
		.rx_frame_idx  (rx_frame_idx),
		.rx_m4_bit     (rx_m4_bit),
		.loop_req      (loop_only_req),
		.loop_valid    (loop_only_valid),
		.loop_chg      (loop_chg)
	);
	//////////////////////////////////////////////////////////////////////
	// RQ3 supply pair maps straight to the code: good is ONE
	assign pwr_pair = {pin_s[0], pin_s[1]};
	// RQ6 test mode from any local maintenance
	assign in_test = pin_s[2] | pin_s[3] | pin_s[4];
	// RQ14 T-side activity
	assign tee_act = pin_s[5] | pin_s[6];
	//////////////////////////////////////////////////////////////////////
	// Bus, encoder and interrupt state in one step
	always_comb begin
		logic [3:0] ev;
		logic       rd_istat;
		oeb_reg_t   sel;
		ev = 4'h0;
		rd_istat = 1'b0;
		sel = OEB_REG_NONE;
		d = q;
		d.tx_valid = 1'b0;
		// Write address and data may arrive in either order
		if (awvalid && q.awready) begin
			d.aw_got = 1'b1;
			d.aw_addr = 8'(awaddr);
			d.awready = 1'b0;
		end
		if (wvalid && q.wready) begin
			d.w_got = 1'b1;
			d.w_byte = wdata[7:0];
			d.w_en = wstrb[0];
			d.wready = 1'b0;
		end
		if (q.bvalid && bready) begin
			d.bvalid = 1'b0;
			d.awready = 1'b1;
			d.wready = 1'b1;
		end
		if (q.aw_got && q.w_got && !q.bvalid) begin
			d.aw_got = 1'b0;
			d.w_got = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = RESP_OKAY;
			sel = oeb_decode(q.aw_addr);
			unique case (sel)
				OEB_REG_CTRL: if (q.w_en) d.ctrl = q.w_byte[3:0];
				OEB_REG_IMASK: if (q.w_en) d.imask = q.w_byte[3:0];
				OEB_REG_STAT, OEB_REG_ISTAT: ;
				OEB_REG_NONE: d.bresp = RESP_SLVERR;
			endcase
		end
		// Read: one answer at a time, data from a register
		if (q.rvalid && rready) begin
			d.rvalid = 1'b0;
			d.arready = 1'b1;
		end
		if (arvalid && q.arready) begin
			d.arready = 1'b0;
			d.rvalid = 1'b1;
			d.rresp = RESP_OKAY;
			d.rdata = 32'h00000000;
			sel = oeb_decode(8'(araddr));
			unique case (sel)
				OEB_REG_CTRL: d.rdata[3:0] = q.ctrl;
				OEB_REG_STAT: d.rdata[6:0] = {nt_active_signal, tee_act,
					in_test, pwr_pair, loop_only_valid, loop_only_req};
				OEB_REG_ISTAT: begin
					d.rdata[3:0] = q.istat;
					rd_istat = 1'b1;
				end
				OEB_REG_IMASK: d.rdata[3:0] = q.imask;
				OEB_REG_NONE: d.rresp = RESP_SLVERR;
			endcase
		end
		// Change events wait until the synchroniser holds real pin levels;
		// its reset zeros would otherwise read as a supply change
		if (q.prime_cnt != PRIME_LAST) d.prime_cnt = q.prime_cnt + 2'h1;
		d.pwr_prev = pwr_pair;
		d.test_prev = in_test;
		d.act_prev = tee_act;
		ev[IB_LOOP] = loop_chg;
		ev[IB_PWR] = (q.prime_cnt == PRIME_LAST) && (pwr_pair != q.pwr_prev);
		ev[IB_TEST] = (q.prime_cnt == PRIME_LAST) && (in_test != q.test_prev);
		ev[IB_ACT] = (q.prime_cnt == PRIME_LAST) && (tee_act != q.act_prev);
		// A read clears, but an event in the same cycle survives it
		d.istat = (rd_istat ? 4'h0 : q.istat) | ev;
		d.irq = |(d.istat & d.imask);
		// Overhead bit for the slot the framer is about to send
		if (tx_m4_req) begin
			d.tx_valid = 1'b1;
			d.tx_bit = 1'b1;
			unique case (tx_frame_idx)
				// RQ1 RQ2 RQ4 power pair or ONE
				FR_PWR_FIRST: d.tx_bit = !q.ctrl[CB_PWR] || pwr_pair[1];
				FR_PWR_SECOND: d.tx_bit = !q.ctrl[CB_PWR] || pwr_pair[0];
				// RQ5 RQ7 RQ8 test mode bit, ZERO in test
				FR_TEST: d.tx_bit = !q.ctrl[CB_TEST] || !in_test;
				// RQ9 cold start capability
				FR_COLD: d.tx_bit = q.ctrl[CB_COLD];
				// RQ13 RQ15 activity bit or ONE
				FR_SEVENTH: d.tx_bit = !q.ctrl[CB_ACT] || tee_act;
				default: d.tx_bit = 1'b1;
			endcase
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) q <= CTL_RST;
		else q <= d;
	end
	//////////////////////////////////////////////////////////////////////
	assign awready = q.awready;
	assign wready = q.wready;
	assign bvalid = q.bvalid;
	assign bresp = q.bresp;
	assign arready = q.arready;
	assign rvalid = q.rvalid;
	assign rresp = q.rresp;
	assign rdata = q.rdata;
	assign irq = q.irq;
	assign tx_m4_bit = q.tx_bit;
	assign tx_m4_valid = q.tx_valid;
	//////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	AST_PWR_FIRST: assert property ( // RQ1
		tx_m4_req && tx_frame_idx == FR_PWR_FIRST && q.ctrl[CB_PWR]
		|=> tx_m4_valid && tx_m4_bit == $past(pin_s[0]))
		else $error("first power bit does not follow primary supply");
	AST_PWR_OFF: assert property ( // RQ2
		tx_m4_req && !q.ctrl[CB_PWR]
		&& (tx_frame_idx == FR_PWR_FIRST || tx_frame_idx == FR_PWR_SECOND)
		|=> tx_m4_valid && tx_m4_bit)
		else $error("power bit not ONE with reporting off");
	AST_PWR_BACKUP: assert property ( // RQ3
		tx_m4_req && tx_frame_idx == FR_PWR_SECOND && q.ctrl[CB_PWR]
		&& pin_s[0] && !pin_s[1]
		|=> tx_m4_valid && !tx_m4_bit)
		else $error("backup failure not coded as 10");
	AST_PWR_DYING: assert property ( // RQ4
		tx_m4_req && tx_frame_idx == FR_PWR_FIRST && q.ctrl[CB_PWR]
		&& !pin_s[0] |=> !tx_m4_bit)
		else $error("primary failure not coded with ZERO first");
	AST_TEST_ON: assert property ( // RQ7
		tx_m4_req && tx_frame_idx == FR_TEST && q.ctrl[CB_TEST]
		&& (pin_s[2] || pin_s[3] || pin_s[4]) |=> tx_m4_valid && !tx_m4_bit)
		else $error("test mode not sent as ZERO");
	AST_TEST_OFF: assert property ( // RQ8
		tx_m4_req && tx_frame_idx == FR_TEST && !q.ctrl[CB_TEST]
		|=> tx_m4_bit)
		else $error("test bit not ONE with reporting off");
	AST_COLD: assert property ( // RQ9
		tx_m4_req && tx_frame_idx == FR_COLD
		|=> tx_m4_valid && tx_m4_bit == $past(q.ctrl[CB_COLD]))
		else $error("cold start bit wrong");
	AST_ACT: assert property ( // RQ14
		tx_m4_req && tx_frame_idx == FR_SEVENTH && q.ctrl[CB_ACT]
		|=> tx_m4_bit == ($past(pin_s[5]) || $past(pin_s[6])))
		else $error("activity bit does not follow T signals");
	AST_ACT_OFF: assert property ( // RQ15
		tx_m4_req && tx_frame_idx == FR_SEVENTH && !q.ctrl[CB_ACT]
		|=> tx_m4_bit)
		else $error("activity bit not ONE with reporting off");
	AST_IRQ_LEVEL: assert property (
		irq == |(q.istat & q.imask))
		else $error("interrupt out of step with status and mask");
	AST_READ_ONE: assert property (
		arvalid && arready |=> rvalid && !arready)
		else $error("read not answered next cycle");
	AST_PRIME_QUIET: assert property (
		q.prime_cnt != PRIME_LAST |=> q.istat[IB_ACT:IB_PWR] == 3'h0)
		else $error("pin change event raised before history was primed");
	AST_EVENT_WINS: assert property (
		loop_chg |=> q.istat[IB_LOOP])
		else $error("received bit change lost from status");
	AST_TX_FILL: assert property (
		tx_m4_req && tx_frame_idx != FR_PWR_FIRST && tx_frame_idx != FR_PWR_SECOND
		&& tx_frame_idx != FR_TEST && tx_frame_idx != FR_COLD
		&& tx_frame_idx != FR_SEVENTH |=> tx_m4_valid && tx_m4_bit)
		else $error("framer-owned slot not answered with ONE");
	AST_TX_PULSE: assert property (
		!tx_m4_req |=> !tx_m4_valid)
		else $error("overhead bit answer without a request");
	AST_WRITE_ANSWER: assert property (
		q.aw_got && q.w_got && !bvalid |=> bvalid)
		else $error("write not answered after address and data");
	AST_RESP_HOLD: assert property (
		bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped before it was taken");
	AST_RDATA_HOLD: assert property (
		rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
		else $error("read data dropped before it was taken");
endmodule // oeb_top
`default_nettype wire

//--- dv/oeb_far_end.sv
// Far-end line terminator model: feeds received overhead bits with framing.
// Assumes the receive port of oeb_top on the same aclk.
`timescale 1ns/1ps
`default_nettype none
module oeb_far_end (
	input  wire logic aclk,
	output logic      rx_mf_aligned,
	output logic      rx_m4_valid,
	output logic [3:0] rx_frame_idx,
	output logic      rx_m4_bit
);
	// Idle framing at time zero
	initial begin
		rx_mf_aligned = 1'b0;
		rx_m4_valid   = 1'b0;
		rx_frame_idx  = 4'h1;
		rx_m4_bit     = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// One multiframe of overhead bits, one frame per cycle
	task automatic send_mf(input logic uoa);
		for (int f = 1; f <= 8; f++) begin
			rx_mf_aligned <= 1'b1;
			rx_m4_valid   <= 1'b1;
			rx_frame_idx  <= f[3:0];
			rx_m4_bit     <= (f == 7) ? uoa : 1'b1;
			@(posedge aclk);
		end
		rx_m4_valid <= 1'b0;
		// Released line shows the inverse, not a stale value
		rx_m4_bit   <= ~rx_m4_bit;
	endtask

	// Alignment is lost or regained at the framer
	task automatic set_align(input logic a);
		rx_mf_aligned <= a;
		@(posedge aclk);
	endtask
endmodule // oeb_far_end
`default_nettype wire

//--- dv/tb_overhead_extension_bits.sv
// Self-checking bench for oeb_top: overhead bit encode, receive capture,
// registers and interrupt. Assumes the far-end model in oeb_far_end.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin samples_checked++; if ((s) !== (e)) begin n_errors++; \
	$display("mismatch %s expected %0h seen %0h", nm, e, s); end end
module tb_overhead_extension_bits;
	import oeb_pkg::*;
	logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, irq, prim_pwr_ok, bkup_pwr_ok;
	logic        maint_d, maint_b1, maint_b2, tee_request_signal, tee_frame_signal;
	logic        nt_active_signal, tx_m4_req, tx_m4_bit, tx_m4_valid;
	logic        rx_mf_aligned, rx_m4_valid, rx_m4_bit, loop_only_req, loop_only_valid;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rd_d;
	logic [3:0]  wstrb, tx_frame_idx, rx_frame_idx;
	logic [1:0]  bresp, rresp, rd_r, wr_r;
	int          n_errors, samples_checked, cyc;

	oeb_top dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .irq(irq), .prim_pwr_ok(prim_pwr_ok),
		.bkup_pwr_ok(bkup_pwr_ok), .maint_d(maint_d), .maint_b1(maint_b1),
		.maint_b2(maint_b2), .tee_request_signal(tee_request_signal),
		.tee_frame_signal(tee_frame_signal), .nt_active_signal(nt_active_signal),
		.tx_m4_req(tx_m4_req), .tx_frame_idx(tx_frame_idx), .tx_m4_bit(tx_m4_bit),
		.tx_m4_valid(tx_m4_valid), .rx_mf_aligned(rx_mf_aligned),
		.rx_m4_valid(rx_m4_valid), .rx_frame_idx(rx_frame_idx), .rx_m4_bit(rx_m4_bit),
		.loop_only_req(loop_only_req), .loop_only_valid(loop_only_valid));
	oeb_far_end far (.aclk(aclk), .rx_mf_aligned(rx_mf_aligned),
		.rx_m4_valid(rx_m4_valid), .rx_frame_idx(rx_frame_idx), .rx_m4_bit(rx_m4_bit));

	// 50 MHz clock
	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end

	// Hang guard; the whole run needs well under a thousand cycles
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 5000) begin
			n_errors++;
			close_out();
		end
	end

	////////////////////////////////////////////////////////////////////////
	task automatic close_out();
		if (n_errors == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Write: address and data offered together, each released when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		// bready stays high so a following write never re-drives it at once
		wr_r = bresp;
	endtask

	// Read: data and response taken at the edge where rvalid is seen
	task automatic rd(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		rd_d = rdata;
		rd_r = rresp;
	endtask

	// Ask for one outgoing overhead bit; answer stands one cycle only
	task automatic txq(input logic [3:0] idx, input logic e, input string nm);
		tx_m4_req <= 1'b1;
		tx_frame_idx <= idx;
		@(posedge aclk);
		tx_m4_req <= 1'b0;
		#1;
		`CHK(nm, 1'b1, tx_m4_valid)
		`CHK(nm, e, tx_m4_bit)
		@(posedge aclk);
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		#1;
		`CHK("tx bit rst", 1'b1, tx_m4_bit)
		`CHK("loop valid rst", 1'b0, loop_only_valid)
		`CHK("irq rst", 1'b0, irq)
		@(posedge aclk);
		rd(OFF_CTRL);
		`CHK("ctrl rst", {28'h0, CTRL_RST}, rd_d)
		rd(OFF_IMASK);
		`CHK("imask rst", {28'h0, IMASK_RST}, rd_d)
		rd(OFF_ISTAT);
		`CHK("istat rst", 32'h0, rd_d)
	endtask

	// All reporting off: fixed ONE, cold bit ZERO
	task automatic t_defaults();
		txq(4'h2, 1'b1, "pwr1 off");
		txq(4'h3, 1'b1, "pwr2 off");
		txq(4'h4, 1'b1, "test off");
		txq(4'h7, 1'b1, "act off");
		txq(4'h5, 1'b0, "cold off");
	endtask

	task automatic t_power();
		wr(OFF_CTRL, 32'h1);
		`CHK("wr resp", RESP_OKAY, wr_r)
		for (int i = 0; i < 4; i++) begin
			{prim_pwr_ok, bkup_pwr_ok} <= i[1:0];
			repeat (5) @(posedge aclk);
			txq(FR_PWR_FIRST, i[1], "pwr first");
			txq(FR_PWR_SECOND, i[0], "pwr second");
			rd(OFF_STAT);
			`CHK("stat pwr", i[1:0], rd_d[3:2])
			`CHK("stat active", 1'b1, rd_d[6])
		end
	endtask

	task automatic t_test();
		wr(OFF_CTRL, 32'h2);
		for (int k = 0; k < 4; k++) begin
			{maint_d, maint_b1, maint_b2} <= (k == 0) ? 3'h0 : 3'h4 >> (k - 1);
			repeat (5) @(posedge aclk);
			txq(FR_TEST, k == 0, "test mode");
		end
		{maint_d, maint_b1, maint_b2} <= 3'h0;
	endtask

	task automatic t_act();
		wr(OFF_CTRL, 32'h4);
		for (int k = 0; k < 3; k++) begin
			tee_request_signal <= (k == 1);
			tee_frame_signal <= (k == 2);
			repeat (5) @(posedge aclk);
			txq(FR_SEVENTH, k != 0, "t activity");
		end
		wr(OFF_CTRL, 32'h8);
		txq(FR_COLD, 1'b1, "cold only");
	endtask

	// Received request captured, masked, unmasked, cleared, dropped
	task automatic t_rx();
		wr(OFF_IMASK, 32'h0);
		far.send_mf(1'b1);
		repeat (3) @(posedge aclk);
		`CHK("loop req", 1'b1, loop_only_req)
		`CHK("loop valid", 1'b1, loop_only_valid)
		`CHK("irq masked", 1'b0, irq)
		rd(OFF_STAT);
		`CHK("stat loop", 2'h3, rd_d[1:0])
		wr(OFF_IMASK, 32'h1);
		repeat (2) @(posedge aclk);
		`CHK("irq on", 1'b1, irq)
		rd(OFF_ISTAT);
		`CHK("istat loop", 1'b1, rd_d[IB_LOOP])
		repeat (2) @(posedge aclk);
		`CHK("irq cleared", 1'b0, irq)
		far.send_mf(1'b0);
		repeat (3) @(posedge aclk);
		`CHK("loop req zero", 1'b0, loop_only_req)
		far.set_align(1'b0);
		repeat (2) @(posedge aclk);
		`CHK("valid dropped", 1'b0, loop_only_valid)
		rd(8'h10);
		`CHK("unmapped resp", RESP_SLVERR, rd_r)
		`CHK("unmapped data", 32'h0, rd_d)
		wr(8'h10, 32'h1);
		`CHK("wr unmapped", RESP_SLVERR, wr_r)
		wstrb <= 4'h0;
		wr(OFF_IMASK, 32'hF);
		rd(OFF_IMASK);
		`CHK("imask no strobe", 32'h1, rd_d)
	endtask

	// Main sequence
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, tx_m4_req} = 7'h0;
		{maint_d, maint_b1, maint_b2, tee_request_signal, tee_frame_signal} = 5'h0;
		{prim_pwr_ok, bkup_pwr_ok, nt_active_signal} = 3'h7;
		{awaddr, araddr, wdata, wstrb, tx_frame_idx} = {16'h0, 32'h0, 4'hF, 4'h1};
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_reset();
		t_defaults();
		t_power();
		t_test();
		t_act();
		t_rx();
		close_out();
	end
endmodule // tb_overhead_extension_bits
`undef CHK
`default_nettype wire
